//--- tcoc_clock_output.sv
// clock output control: serial registers, rate divider, doze stop and attention wake
`timescale 1ns/100ps
`default_nettype none
`include "tcoc_regs.svh"

module tcoc_clock_output #(
	parameter int DIV_W = `TCOC_DIV_W,
	parameter int DOZE_STOP_CYCLES = `TCOC_DOZE_STOP_REF_CYCLES
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire tcoc_pkg::tcoc_spi_in_s spi_in,
	output tcoc_pkg::tcoc_spi_out_s spi_out,
	input wire logic ref_clk,
	input wire logic attn_n,
	input wire logic timer_compare_wake,
	output logic clko,
	output logic [1:0] clko_drive,
	output logic [7:0] xtal_trim,
	output logic dozing,
	output logic irq_n
);
	import tcoc_pkg::*;

	initial begin
		if (DIV_W < 10) $error("DIV_W must reach the 1024 divide");
		if (DOZE_STOP_CYCLES < 1 || DOZE_STOP_CYCLES > 256) $error("DOZE_STOP_CYCLES out of range");
	end

	////////////////////////////////////////////////////////////////////////////
	// input synchronisation and edges

	logic [4:0] pin_q;
	logic ce_n_q;
	logic sclk_q;
	logic mosi_q;
	logic attn_q;
	logic ref_q;
	logic sclk_d;
	logic attn_d;
	logic ref_d;

	tcoc_sync #(
		.WIDTH(5)
	) u_sync (
		.mclk(mclk),
		.reset_n(reset_n),
		.din({~spi_in.ce_n, spi_in.sclk, spi_in.mosi, ~attn_n, ref_clk}), // low-true pins inverted: reset reads idle
		.dout(pin_q)
	);

	assign ce_n_q = ~pin_q[4];
	assign sclk_q = pin_q[3];
	assign mosi_q = pin_q[2];
	assign attn_q = ~pin_q[1];
	assign ref_q = pin_q[0];

	// previous filtered levels; attention idles high
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sclk_d <= 1'b0;
			attn_d <= 1'b1;
			ref_d <= 1'b0;
		end else begin
			sclk_d <= sclk_q;
			attn_d <= attn_q;
			ref_d <= ref_q;
		end
	end

	logic sclk_rise;
	logic sclk_fall;
	logic attn_fall;
	logic ref_rise;
	assign sclk_rise = sclk_q & ~sclk_d & ~ce_n_q;
	assign sclk_fall = ~sclk_q & sclk_d & ~ce_n_q;
	assign attn_fall = attn_d & ~attn_q;
	assign ref_rise = ref_q & ~ref_d;

	////////////////////////////////////////////////////////////////////////////
	// serial frame: command byte (read bit 7, address 5..0) then 16 data bits

	logic [4:0] bit_cnt;
	logic [15:0] shift_in;
	logic [15:0] shift_out;
	logic [5:0] frame_addr;
	logic frame_read;
	logic [5:0] cmd_addr;
	logic cmd_read;
	logic cmd_done;
	logic rd_load;
	logic wr_done;
	logic [15:0] wr_data;
	logic [15:0] rd_data;

	assign cmd_addr = {shift_in[4:0], mosi_q};
	assign cmd_read = shift_in[`TCOC_CMD_READ_BIT - 1];
	assign cmd_done = sclk_rise && (bit_cnt == 5'(`TCOC_CMD_BITS - 1));
	assign rd_load = cmd_done && cmd_read;
	assign wr_done = sclk_rise && (bit_cnt == 5'(`TCOC_FRAME_BITS - 1)) && !frame_read;
	assign wr_data = {shift_in[14:0], mosi_q};

	// bit counter, input shifter and latched command; chip enable high aborts the frame
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			bit_cnt <= '0;
			shift_in <= '0;
			frame_addr <= '0;
			frame_read <= 1'b0;
		end else if (ce_n_q) begin
			bit_cnt <= '0;
			frame_read <= 1'b0;
		end else if (sclk_rise && bit_cnt < 5'(`TCOC_FRAME_BITS)) begin
			bit_cnt <= bit_cnt + 5'd1;
			shift_in <= wr_data;
			if (cmd_done) begin
				frame_addr <= cmd_addr;
				frame_read <= cmd_read;
			end
		end
	end

	// output shifter: loaded at the last command edge, shifted on later falling edges
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			shift_out <= '0;
		end else if (rd_load) begin
			shift_out <= rd_data;
		end else if (sclk_fall && frame_read && bit_cnt > 5'(`TCOC_CMD_BITS)) begin
			shift_out <= {shift_out[14:0], 1'b0};
		end
	end

	// data out only driven during the data phase of a read
	assign spi_out.miso = shift_out[15];
	assign spi_out.miso_oe_n = ~(~ce_n_q && frame_read);

	////////////////////////////////////////////////////////////////////////////
	// register file

	logic [15:0] interrupt_mask;
	logic [15:0] control_b;
	logic [15:0] control_c;
	logic [15:0] clock_out_control;
	logic [15:0] pin_data_out;
	logic attn_flag;

	function automatic logic wr_hit(input logic stb, input logic [5:0] a, input logic [5:0] ofs);
		wr_hit = stb && (a == ofs);
	endfunction : wr_hit

	// read mux; unmapped addresses and reserved status bits read zero
	always_comb begin
		case (cmd_addr)
			`TCOC_OFS_INTERRUPT_MASK: rd_data = interrupt_mask;
			`TCOC_OFS_CONTROL_B: rd_data = control_b;
			`TCOC_OFS_CONTROL_C: rd_data = control_c;
			`TCOC_OFS_CLOCK_OUT_CONTROL: rd_data = clock_out_control;
			`TCOC_OFS_PIN_DATA_OUT: rd_data = pin_data_out;
			`TCOC_OFS_INTERRUPT_STATUS: rd_data = 16'(attn_flag) << `TCOC_BIT_ATTN_FLAG;
			default: rd_data = 16'h0000;
		endcase
	end

	logic rd_clr_status;
	logic attn_set;
	logic wake;
	logic doze_req;
	logic doze_keep;
	logic clko_en;
	logic [2:0] rate;
	tcoc_state_e state;

	assign rd_clr_status = wr_hit(rd_load, cmd_addr, `TCOC_OFS_INTERRUPT_STATUS);
	assign doze_req = control_b[`TCOC_BIT_DOZE_REQ];
	assign doze_keep = control_b[`TCOC_BIT_DOZE_KEEP];
	assign clko_en = control_c[`TCOC_BIT_CLKO_EN];
	assign rate = clock_out_control[`TCOC_RATE_MSB:`TCOC_RATE_LSB];

	// attention wake: either wake source ends doze
	assign wake = (state != CK_RUN) && (attn_fall || timer_compare_wake);
	// attention status set only by an attention-caused wake
	assign attn_set = (state != CK_RUN) && attn_fall;

	logic next_attn_flag;
	logic [15:0] next_control_b;
	// read clears status; a simultaneous wake still sets it
	assign next_attn_flag = attn_set || (attn_flag && !rd_clr_status);
	// doze request drops by itself on wake so software need not clear it
	assign next_control_b = wr_hit(wr_done, frame_addr, `TCOC_OFS_CONTROL_B) ? wr_data :
		wake ? (control_b & ~(16'h0001 << `TCOC_BIT_DOZE_REQ)) : control_b;

	// enabled at the default rate out of reset
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			interrupt_mask <= `TCOC_RST_INTERRUPT_MASK;
			control_b <= `TCOC_RST_CONTROL_B;
			control_c <= `TCOC_RST_CONTROL_C;
			clock_out_control <= `TCOC_RST_CLOCK_OUT_CONTROL;
			pin_data_out <= `TCOC_RST_PIN_DATA_OUT;
			attn_flag <= 1'b0;
		end else begin
			if (wr_hit(wr_done, frame_addr, `TCOC_OFS_INTERRUPT_MASK)) interrupt_mask <= wr_data;
			if (wr_hit(wr_done, frame_addr, `TCOC_OFS_CONTROL_C)) control_c <= wr_data;
			if (wr_hit(wr_done, frame_addr, `TCOC_OFS_CLOCK_OUT_CONTROL)) clock_out_control <= wr_data;
			if (wr_hit(wr_done, frame_addr, `TCOC_OFS_PIN_DATA_OUT)) pin_data_out <= wr_data;
			control_b <= next_control_b;
			attn_flag <= next_attn_flag;
		end
	end

	// trim passed to the oscillator warp drive level to the pad
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			xtal_trim <= 8'h00;
			clko_drive <= 2'h0;
			irq_n <= 1'b1;
		end else begin
			xtal_trim <= clock_out_control[`TCOC_TRIM_MSB:`TCOC_TRIM_LSB];
			clko_drive <= pin_data_out[`TCOC_DRIVE_MSB:`TCOC_DRIVE_LSB];
			irq_n <= ~(attn_flag && interrupt_mask[`TCOC_BIT_ATTN_MASK]);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// doze sequencing

	logic [7:0] doze_cnt;
	logic doze_cnt_last;
	tcoc_state_e next_state;
	assign doze_cnt_last = ref_rise && (doze_cnt == 8'(DOZE_STOP_CYCLES - 1));

	// keep toggling count then stop auto restart
	always_comb begin
		next_state = state;
		case (state)
			CK_RUN: begin
				if (doze_req) next_state = doze_keep ? CK_KEEP : (clko_en ? CK_WAIT : CK_STOP);
			end
			CK_WAIT: begin
				if (wake) next_state = CK_RUN;
				else if (doze_cnt_last) next_state = CK_STOP;
			end
			CK_STOP: begin
				if (wake) next_state = CK_RUN;
			end
			CK_KEEP: begin
				if (wake) next_state = CK_RUN;
			end
			default: next_state = CK_RUN;
		endcase
	end

	// count reference edges only while waiting to stop
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state <= CK_RUN;
			doze_cnt <= '0;
		end else begin
			state <= next_state;
			doze_cnt <= (state == CK_WAIT) ? doze_cnt + 8'(ref_rise) : 8'h00;
		end
	end

	assign dozing = (state != CK_RUN);

	////////////////////////////////////////////////////////////////////////////
	// rate divider

	// power-of-two divide per code; 110 approximates the low default rate
	function automatic logic [3:0] rate_shift(input logic [2:0] r);
		case (r)
			3'h6: rate_shift = 4'h9;
			3'h7: rate_shift = 4'hA;
			default: rate_shift = {1'b0, r};
		endcase
	endfunction : rate_shift

	logic [DIV_W-1:0] div_cnt;
	logic [3:0] div_sh;
	logic div_sel;
	logic clko_run;
	logic next_clko;

	assign div_sh = rate_shift(rate);
	// code 000 routes the reference level itself
	assign div_sel = (div_sh == 4'h0) ? ref_q : div_cnt[div_sh - 4'h1];
	assign clko_run = (state == CK_RUN) || (state == CK_WAIT) || (state == CK_KEEP);
	// enable gates the pin; a stopped clock freezes at its last level
	assign next_clko = !clko_en ? 1'b0 : (clko_run ? div_sel : clko);

	// divider runs freely on reference edges so restart needs no reload
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			div_cnt <= '0;
			clko <= 1'b0;
		end else begin
			div_cnt <= div_cnt + DIV_W'(ref_rise);
			clko <= next_clko;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	sequence seq_doze_enter;
		(state == CK_RUN) ##1 (state != CK_RUN);
	endsequence

	chk_stop_after_count: assert property ((state == CK_WAIT) && doze_cnt_last && !wake |=> state == CK_STOP)
		else $error("clock did not stop after the doze count");
	chk_stop_frozen: assert property ((state == CK_STOP) && clko_en ##1 (state == CK_STOP) && clko_en |-> $stable(clko))
		else $error("clock toggled while stopped in doze");
	chk_keep_entry: assert property (seq_doze_enter |-> (state == CK_KEEP) == $past(doze_keep))
		else $error("doze keep not honoured");
	chk_wake_restart: assert property ((state != CK_RUN) && attn_fall |=> state == CK_RUN ##1 !doze_req)
		else $error("attention did not end doze");
	chk_attn_flag_set: assert property ((state != CK_RUN) && attn_fall |=> attn_flag [*2])
		else $error("attention wake did not set status");
	chk_irq_masked: assert property (attn_flag && interrupt_mask[`TCOC_BIT_ATTN_MASK] |=> !irq_n)
		else $error("unmasked attention gave no request");
	chk_read_clear: assert property (rd_clr_status && !attn_set |=> !attn_flag)
		else $error("status read did not clear the flag");
	chk_disabled_low: assert property (!clko_en ##1 !clko_en |-> !clko)
		else $error("output clock active while disabled");
	chk_direct_ref: assert property (clko_run && clko_en && (rate == 3'h0) |=> clko == $past(ref_q))
		else $error("code 000 did not pass the reference");
	chk_timer_wake: assert property ((state != CK_RUN) && timer_compare_wake |=> state == CK_RUN)
		else $error("timer compare did not end doze");

endmodule : tcoc_clock_output

`default_nettype wire

//--- tcoc_regs.svh
// register offsets, field positions, reset values and timing counts of the clock output block
// Summary of operation
// - Control-C bit 5 set drives the selected output clock on the pin.
// - After reset the output clock is enabled at the low default rate.
// - Rate field bits 2..0 selects 16 MHz down to 16 kHz, reset 110.
// - Rate code 000 passes the undivided reference straight to the pin.
// - Trim field bits 15..8 sets crystal warp; zero is the fastest.
// - Doze keep bit (control-B bit 9) keeps the clock toggling in doze.
// - Without keep, the clock stops 128 reference cycles after the doze request.
// - Leaving doze restarts the output clock with no software help.
// - Drive field bits 11..10 of pin data-out picks drive, reset 00.
// - A falling edge on the attention input always ends doze.
// - Attention wake sets status bit 10; mask bit 15 raises the request.
// - Reading the interrupt status register clears its pending flags.
`ifndef TCOC_REGS_SVH
`define TCOC_REGS_SVH

`define TCOC_ADDR_W 6
`define TCOC_DATA_W 16
`define TCOC_FRAME_BITS 24
`define TCOC_CMD_BITS 8
`define TCOC_CMD_READ_BIT 7

`define TCOC_OFS_INTERRUPT_MASK 6'h05
`define TCOC_OFS_CONTROL_B 6'h07
`define TCOC_OFS_CONTROL_C 6'h09
`define TCOC_OFS_CLOCK_OUT_CONTROL 6'h0A
`define TCOC_OFS_PIN_DATA_OUT 6'h0C
`define TCOC_OFS_INTERRUPT_STATUS 6'h24

`define TCOC_BIT_CLKO_EN 5
`define TCOC_BIT_DOZE_REQ 1
`define TCOC_BIT_DOZE_KEEP 9
`define TCOC_BIT_ATTN_FLAG 10
`define TCOC_BIT_ATTN_MASK 15
`define TCOC_RATE_LSB 0
`define TCOC_RATE_MSB 2
`define TCOC_TRIM_LSB 8
`define TCOC_TRIM_MSB 15
`define TCOC_DRIVE_LSB 10
`define TCOC_DRIVE_MSB 11

`define TCOC_RST_INTERRUPT_MASK 16'h8000
`define TCOC_RST_CONTROL_B 16'h0000
`define TCOC_RST_CONTROL_C 16'h0020
`define TCOC_RST_CLOCK_OUT_CONTROL 16'h0006
`define TCOC_RST_PIN_DATA_OUT 16'h0000

`define TCOC_DIV_W 10
`define TCOC_DOZE_STOP_REF_CYCLES 128

`endif

//--- tcoc_pkg.sv
// types shared by the clock output block
package tcoc_pkg;

	// serial register port pins, already inside the chip boundary
	typedef struct packed {
		logic ce_n;
		logic sclk;
		logic mosi;
	} tcoc_spi_in_s;

	typedef struct packed {
		logic miso;
		logic miso_oe_n;
	} tcoc_spi_out_s;

	// output clock lifecycle around doze
	typedef enum logic [1:0] {
		CK_RUN,
		CK_WAIT,
		CK_STOP,
		CK_KEEP
	} tcoc_state_e;

endpackage : tcoc_pkg

//--- tcoc_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none

module tcoc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;
	logic [WIDTH-1:0] next_dout;

	initial begin
		if (WIDTH < 1) $error("tcoc_sync needs WIDTH of at least 1");
	end

	// a bit only moves once stages two and three agree, so one glitch sample never counts
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			assign next_dout[g] = (s2[g] == s3[g]) ? s3[g] : dout[g];
		end
	endgenerate

	// stage one feeds stage two only
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			dout <= '0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			dout <= next_dout;
		end
	end

endmodule : tcoc_sync

`default_nettype wire

//--- tcoc_clk_user.sv
// far-side clock user: counts output clock edges and times the latest period
`timescale 1ns/100ps
`default_nettype none

module tcoc_clk_user (
	input wire logic clko,
	output var int edges,
	output var real per_ns
);
	realtime last = 0;
	int cnt = 0;
	real per = 0.0;

	assign edges = cnt;
	assign per_ns = per;

	// runs on the output clock itself, so a stopped clock freezes the count
	always @(posedge clko) begin
		per = $realtime - last;
		last = $realtime;
		cnt++;
	end
endmodule : tcoc_clk_user

`default_nettype wire

//--- transceiver_clock_output_control_tb.sv
// self-checking bench for the clock output block
`timescale 1ns/100ps
`default_nettype none
`include "tcoc_regs.svh"

module transceiver_clock_output_control_tb;
	import tcoc_pkg::*;
	localparam int STOP_N = 8; // shortened doze stop count keeps the run brief
	localparam real REF_HALF = 31.3;
	logic mclk = 0;
	logic reset_n = 0;
	logic ref_clk = 0;
	logic attn_n = 1;
	logic tmr_wake = 0;
	tcoc_spi_in_s spi = '{1'b1, 1'b0, 1'b0};
	tcoc_spi_out_s spo;
	logic clko;
	logic irq_n;
	logic dozing;
	logic [1:0] drv;
	logic [7:0] trim;
	int edges;
	int error_cnt = 0;
	int tests_run = 0;
	int cyc = 0;
	int e0;
	real per_ns;
	logic [15:0] q[$];
	logic [15:0] r_val;
	logic [15:0] rd_v;
	logic oe_seen;
	string r_name;
	event got_ev;

	always #2.5 mclk = ~mclk;
	// reference runs unrelated to mclk, as the real oscillator would
	always #(REF_HALF) ref_clk = ~ref_clk;

	tcoc_clock_output #(.DOZE_STOP_CYCLES(STOP_N)) uut (.mclk(mclk), .reset_n(reset_n), .spi_in(spi),
		.spi_out(spo), .ref_clk(ref_clk), .attn_n(attn_n), .timer_compare_wake(tmr_wake), .clko(clko),
		.clko_drive(drv), .xtal_trim(trim), .dozing(dozing), .irq_n(irq_n));
	tcoc_clk_user far (.clko(clko), .edges(edges), .per_ns(per_ns));

	////////////////////////////////////////////////////////////
	// serial frame, mode 0; miso taken at the end of each low half of the 16 data bits
	task automatic frame(input logic rd, input logic [5:0] a, input logic [15:0] d, output logic [15:0] v);
		logic [23:0] f;
		f = {rd, 1'b0, a, d};
		v = '0;
		spi.ce_n <= 1'b0;
		for (int i = 23; i >= 0; i--) begin
			spi.sclk <= 1'b0;
			spi.mosi <= f[i];
			repeat (8) @(posedge mclk);
			if (i < 16) v[i] = spo.miso;
			if (i == 8) oe_seen = spo.miso_oe_n;
			spi.sclk <= 1'b1;
			repeat (8) @(posedge mclk);
		end
		spi.sclk <= 1'b0;
		repeat (8) @(posedge mclk);
		spi.ce_n <= 1'b1;
		repeat (8) @(posedge mclk);
	endtask : frame

	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		frame(1'b0, a, d, rd_v);
	endtask : wr

	// note the expectation, then hand the result to the watcher
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		q.push_back(e);
		r_name = n;
		r_val = g;
		-> got_ev;
		@(posedge mclk);
	endtask : chk

	task automatic rchk(input logic [5:0] a, input logic [15:0] e);
		frame(1'b1, a, 16'h0000, rd_v);
		chk("register", e, rd_v);
		chk("miso_oe_n read", 16'h0000, {15'h0, oe_seen});
		chk("miso_oe_n idle", 16'h0001, {15'h0, spo.miso_oe_n});
	endtask : rchk

	// waits two edges so a rate change mid-period is not measured
	task automatic per_chk(input int div);
		e0 = edges;
		wait (edges >= e0 + 2);
		chk("clko period", 16'(div), 16'($rtoi(per_ns / (2.0 * REF_HALF) + 0.5)));
	endtask : per_chk

	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : report_and_stop

	// watcher: oldest note against each result as it appears
	initial forever begin
		@(got_ev);
		tests_run++;
		if (r_val !== q[0]) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", r_name, q[0], r_val);
		end
		void'(q.pop_front());
	end

	// hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 100000) begin
			error_cnt++;
			report_and_stop();
		end
	end

	////////////////////////////////////////////////////////////
	initial begin
		int div;
		logic [7:0] t;
		void'($urandom(36));
		repeat (12) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (8) @(posedge mclk);
		chk("clko_drive", 16'h0000, {14'h0, drv}); // weakest drive
		chk("irq_n", 16'h0001, {15'h0, irq_n}); // no request yet
		rchk(`TCOC_OFS_INTERRUPT_MASK, 16'h8000); // mask default
		rchk(`TCOC_OFS_CONTROL_B, 16'h0000); // keep bit clear
		rchk(`TCOC_OFS_CONTROL_C, 16'h0020); // enabled out of reset
		rchk(`TCOC_OFS_CLOCK_OUT_CONTROL, 16'h0006); // rate 110
		rchk(`TCOC_OFS_PIN_DATA_OUT, 16'h0000); // drive 00
		rchk(6'h3F, 16'h0000);
		per_chk(512); // default slow rate
		$display("test reset values done");
		wr(`TCOC_OFS_PIN_DATA_OUT, 16'h0C00); // highest drive for 16 MHz
		for (int c = 0; c < 8; c++) begin
			t = 8'($urandom);
			div = (c == 6) ? 512 : (c == 7) ? 1024 : (1 << c);
			wr(`TCOC_OFS_CLOCK_OUT_CONTROL, {t, 5'h00, 3'(c)});
			chk("xtal_trim", {8'h00, t}, {8'h00, trim}); // trim field
			per_chk(div); // rate codes
			rchk(`TCOC_OFS_CLOCK_OUT_CONTROL, {t, 5'h00, 3'(c)});
		end
		for (int d = 0; d < 4; d++) begin
			wr(`TCOC_OFS_PIN_DATA_OUT, {4'h0, 2'(d), 10'h000});
			chk("clko_drive", 16'(d), {14'h0, drv}); // drive codes
		end
		$display("test rates and drive done");
		wr(`TCOC_OFS_CLOCK_OUT_CONTROL, 16'h0000);
		wr(`TCOC_OFS_CONTROL_C, 16'h0000);
		e0 = edges;
		repeat (200) @(posedge mclk);
		chk("clko off edges", 16'h0000, 16'(edges - e0)); // disabled
		chk("clko low", 16'h0000, {15'h0, clko}); // held low
		wr(`TCOC_OFS_CONTROL_C, 16'h0020);
		e0 = edges;
		repeat (200) @(posedge mclk);
		chk("clko on", 16'h0001, {15'h0, (edges - e0) > 10}); // enable
		$display("test enable done");
		wr(`TCOC_OFS_CONTROL_B, 16'h0002);
		e0 = edges;
		chk("dozing", 16'h0001, {15'h0, dozing}); // doze entered
		repeat (250) @(posedge mclk);
		chk("edges to stop", 16'h0001, {15'h0, (edges - e0) <= STOP_N && (edges - e0) >= STOP_N - 3});
		e0 = edges;
		repeat (200) @(posedge mclk);
		chk("stopped", 16'h0000, 16'(edges - e0)); // clock stopped
		attn_n <= 1'b0;
		repeat (10) @(posedge mclk);
		chk("dozing", 16'h0000, {15'h0, dozing}); // attention wake
		chk("irq_n", 16'h0000, {15'h0, irq_n}); // unmasked request
		attn_n <= 1'b1;
		e0 = edges;
		repeat (200) @(posedge mclk);
		chk("restart", 16'h0001, {15'h0, (edges - e0) > 10}); // auto restart
		rchk(`TCOC_OFS_CONTROL_B, 16'h0000); // request cleared
		wr(`TCOC_OFS_INTERRUPT_STATUS, 16'h0000);
		rchk(`TCOC_OFS_INTERRUPT_STATUS, 16'h0400); // flag then clear
		chk("irq_n", 16'h0001, {15'h0, irq_n}); // read clears
		rchk(`TCOC_OFS_INTERRUPT_STATUS, 16'h0000); // flag gone
		$display("test doze stop and wake done");
		wr(`TCOC_OFS_INTERRUPT_MASK, 16'h0000);
		wr(`TCOC_OFS_CLOCK_OUT_CONTROL, 16'h0004); // 1 MHz before keep
		wr(`TCOC_OFS_CONTROL_B, 16'h0202);
		repeat (300) @(posedge mclk);
		e0 = edges;
		repeat (400) @(posedge mclk);
		chk("kept", 16'h0001, {15'h0, dozing && (edges - e0) > 0}); // keep in doze
		tmr_wake <= 1'b1;
		@(posedge mclk);
		tmr_wake <= 1'b0;
		repeat (4) @(posedge mclk);
		chk("dozing", 16'h0000, {15'h0, dozing}); // timer wake
		wr(`TCOC_OFS_CONTROL_B, 16'h0002);
		attn_n <= 1'b0;
		repeat (10) @(posedge mclk);
		attn_n <= 1'b1;
		chk("masked irq_n", 16'h0001, {15'h0, irq_n}); // mask off
		rchk(`TCOC_OFS_INTERRUPT_STATUS, 16'h0400); // flag still set
		$display("test keep and mask done");
		report_and_stop();
	end
endmodule : transceiver_clock_output_control_tb

`default_nettype wire
